/* File: rtl/console_key_sequencer.v */
`timescale 1ns/1ps
`include "key_seq_defs.vh"
module console_key_sequencer #(
	parameter [`KEY_CNT_W-1:0] REPEAT_CYC = `REPEAT_DELAY_CYC,
	parameter [`KEY_CNT_W-1:0] STOP_PG_CYC = `STOP_PG_CYC
) (
	input  wire                  mclk,
	input  wire                  arst_n,
	input  wire                  power_clear,
	input  wire                  key_start,
	input  wire                  key_read_in,
	input  wire                  key_inst_cont,
	input  wire                  key_mem_cont,
	input  wire                  key_examine,
	input  wire                  key_examine_next,
	input  wire                  key_deposit,
	input  wire                  key_deposit_next,
	input  wire                  key_execute,
	input  wire                  key_io_reset,
	input  wire                  key_exec_mode,
	input  wire                  key_inst_stop,
	input  wire                  key_mem_stop,
	input  wire                  sw_repeat,
	input  wire [`ADDR_W-1:0]    sw_address,
	input  wire [`DATA_W-1:0]    sw_data,
	input  wire                  execute_pulse_0,
	input  wire                  exec_mode,
	input  wire                  jump_restore_instr,
	input  wire [`DATA_W-1:0]    instr_word,
	input  wire                  store_pulse_7,
	input  wire                  inst_fetched,
	input  wire [`ADDR_W-1:0]    fetch_addr,
	input  wire                  mem_done,
	input  wire                  mem_stop_set,
	output reg                   master_clear,
	output reg                   system_init_pulse,
	output reg                   launch_pulse,
	output reg                   next_inst_pulse,
	output reg                   exec_entry_pulse,
	output reg                   memory_cycle_restart,
	output reg                   mem_read_req,
	output reg                   mem_write_req,
	output reg                   operating_flag,
	output reg                   readin_mode,
	output reg                   console_rdwr_flag,
	output reg                   key_pulse_a0,
	output reg                   key_pulse_1,
	output reg                   key_pulse_3,
	output reg                   key_pulse_4,
	output reg  [`ADDR_W-1:0]    memory_address_reg,
	output reg  [`DATA_W-1:0]    accumulate_register,
	output reg  [`DATA_W-1:0]    buffer_register
);
	// ************************************************************
	// pin synchronisers
	// ************************************************************
	localparam NK = 16;
	wire [NK-1:0] raw = {key_start, key_read_in, key_inst_cont, key_mem_cont,
		key_examine, key_examine_next, key_deposit, key_deposit_next,
		key_execute, key_io_reset, key_exec_mode, key_inst_stop,
		key_mem_stop, sw_repeat, power_clear, 1'b0};
	reg [NK-1:0] s1_q;
	reg [NK-1:0] s2_q;
	reg [`ADDR_W-1:0] a1_q;
	reg [`ADDR_W-1:0] a2_q;
	reg [`DATA_W-1:0] d1_q;
	reg [`DATA_W-1:0] d2_q;

	// two flops on every console pin before any logic reads it
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			s1_q <= 16'h0000;
			s2_q <= 16'h0000;
			a1_q <= 18'h0_0000;
			a2_q <= 18'h0_0000;
			d1_q <= 36'h0_0000_0000;
			d2_q <= 36'h0_0000_0000;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
			a1_q <= sw_address;
			a2_q <= a1_q;
			d1_q <= sw_data;
			d2_q <= d1_q;
		end
	end

	wire k_start  = s2_q[15];
	wire k_rdin   = s2_q[14];
	wire k_icont  = s2_q[13];
	wire k_mcont  = s2_q[12];
	wire k_exa    = s2_q[11];
	wire k_exan   = s2_q[10];
	wire k_dep    = s2_q[9];
	wire k_depn   = s2_q[8];
	wire k_exe    = s2_q[7];
	wire k_iorst  = s2_q[6];
	wire k_exmode = s2_q[5];
	wire k_istop  = s2_q[4];
	wire k_mstop  = s2_q[3];
	wire k_rpt    = s2_q[2];
	wire pwr_clr  = s2_q[1];

	// ************************************************************
	// composite key functions
	// ************************************************************
	wire exe_ok   = k_exe & ~operating_flag;
	wire is_exam  = k_exa | k_exan;
	wire is_dep   = k_dep | k_depn;
	// stop keys excluded; whole net dead while power clear is up
	wire key_lvl  = ~pwr_clr & (k_start | k_rdin | k_icont | k_mcont | is_exam
		| is_dep | exe_ok | k_iorst | k_exmode);
	wire go_op    = k_start | k_rdin | k_icont;
	reg  key_lvl_q;
	reg  pwr_clr_q;

	// ************************************************************
	// key time chain
	// ************************************************************
	reg [2:0] st_q;
	reg       sync_exa_q;
	reg       sync_dep_q;
	reg       start_exa_q;
	reg       start_dep_q;
	reg       op_mcont_q;
	reg       op_exe_q;
	reg       op_go_q;
	reg       op_rd_q;
	reg       wr_q;
	wire      any_start = start_exa_q | start_dep_q;
	wire      ep0_waiting = operating_flag & execute_pulse_0 & (st_q == `KS_WAIT_STORE);
	wire      rpt_done;
	wire      pg_done;
	reg       pg_arm_q;

	key_delay #(
		.COUNT (REPEAT_CYC)
	) u_repeat (
		.mclk   (mclk),
		.arst_n (arst_n),
		.start  (key_pulse_4 & k_rpt),
		.abort  (pwr_clr),
		.done   (rpt_done)
	);

	// slow backup path for instruction stop, independent of the chain
	key_delay #(
		.COUNT (STOP_PG_CYC)
	) u_stop_pg (
		.mclk   (mclk),
		.arst_n (arst_n),
		.start  (k_istop & ~pg_arm_q),
		.abort  (1'b0),
		.done   (pg_done)
	);

	// chain sequencing; every pulse output is cleared each cycle first
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st_q                 <= `KS_IDLE;
			key_lvl_q            <= 1'b0;
			pwr_clr_q            <= 1'b0;
			pg_arm_q             <= 1'b0;
			sync_exa_q           <= 1'b0;
			sync_dep_q           <= 1'b0;
			start_exa_q          <= 1'b0;
			start_dep_q          <= 1'b0;
			op_mcont_q           <= 1'b0;
			op_exe_q             <= 1'b0;
			op_go_q              <= 1'b0;
			op_rd_q              <= 1'b0;
			wr_q                 <= 1'b0;
			master_clear         <= 1'b0;
			system_init_pulse    <= 1'b0;
			launch_pulse         <= 1'b0;
			next_inst_pulse      <= 1'b0;
			exec_entry_pulse     <= 1'b0;
			memory_cycle_restart <= 1'b0;
			mem_read_req         <= 1'b0;
			mem_write_req        <= 1'b0;
			operating_flag       <= 1'b0;
			readin_mode          <= 1'b0;
			console_rdwr_flag    <= 1'b0;
			key_pulse_a0         <= 1'b0;
			key_pulse_1          <= 1'b0;
			key_pulse_3          <= 1'b0;
			key_pulse_4          <= 1'b0;
			memory_address_reg   <= 18'h0_0000;
			accumulate_register  <= 36'h0_0000_0000;
			buffer_register      <= 36'h0_0000_0000;
		end else begin
			key_lvl_q            <= key_lvl;
			pwr_clr_q            <= pwr_clr;
			pg_arm_q             <= k_istop;
			master_clear         <= 1'b0;
			system_init_pulse    <= 1'b0;
			launch_pulse         <= 1'b0;
			next_inst_pulse      <= 1'b0;
			exec_entry_pulse     <= 1'b0;
			memory_cycle_restart <= 1'b0;
			mem_read_req         <= 1'b0;
			mem_write_req        <= 1'b0;
			key_pulse_a0         <= 1'b0;
			key_pulse_1          <= 1'b0;
			key_pulse_3          <= 1'b0;
			key_pulse_4          <= 1'b0;

			// power clear onset and the two clearing keys only
			if ((pwr_clr & ~pwr_clr_q) | (key_pulse_1 & (k_iorst | k_exmode))) begin
				system_init_pulse <= 1'b1;
			end
			// readin spans sequences: the init pulse, a fetch above fast memory, or pulse 1 of a key other than read in or a continue key ends it
			if (system_init_pulse | (inst_fetched & (fetch_addr > `FAST_MEM_TOP))) begin
				readin_mode <= 1'b0;
			end

			// start flop arms only while a key op waits; a stale sync would stall the run
			start_exa_q <= start_exa_q | (ep0_waiting & sync_exa_q);
			start_dep_q <= start_dep_q | (ep0_waiting & sync_dep_q);

			// program stop by executive jump restore bit 10, or stop key by gate or backup
			if ((execute_pulse_0 & exec_mode & jump_restore_instr
				& instr_word[`DATA_W-1-`EXEC_STOP_BIT]) | (k_istop & execute_pulse_0) | pg_done) begin
				operating_flag <= 1'b0;
			end

			// end of main sequence while running; a waiting key op with no start flop yet
			// must not hold the processor up
			if (store_pulse_7 & operating_flag) begin
				if (!any_start) begin
					next_inst_pulse <= 1'b1;
					master_clear    <= 1'b1;
				end
			end

			// repeat mode: store pulse 7 with stop held, or the memory stop flop setting
			if (k_rpt & ((store_pulse_7 & op_go_q & k_istop) | (mem_stop_set & k_mstop))) begin
				key_pulse_4 <= 1'b1;
			end

			case (st_q)
			`KS_IDLE: begin
				// rising key level or repeat expiry starts the chain
				if ((key_lvl & ~key_lvl_q) | (rpt_done & key_lvl)) begin
					st_q         <= `KS_A0;
					key_pulse_a0 <= 1'b1;
					op_mcont_q   <= k_mcont;
					op_exe_q     <= exe_ok;
					op_go_q      <= go_op;
					op_rd_q      <= is_exam;
					wr_q         <= is_dep;
					// a0: clear all four, or set the matching sync flop
					sync_exa_q   <= is_exam;
					sync_dep_q   <= is_dep;
					start_exa_q  <= 1'b0;
					start_dep_q  <= 1'b0;
				end
			end
			`KS_A0: begin
				if (op_mcont_q | ~operating_flag) begin
					st_q <= `KS_P1;
				end else if (op_rd_q | wr_q) begin
					st_q <= `KS_WAIT_STORE;
				end else begin
					st_q <= `KS_IDLE;
				end
			end
			`KS_WAIT_STORE: begin
				// final store pulse with a start flop set enters the key cycle
				if (store_pulse_7 & any_start) begin
					st_q <= `KS_P1;
				end else if (~operating_flag) begin
					st_q <= `KS_P1;
				end
			end
			`KS_P1: begin
				key_pulse_1 <= 1'b1;
				if (op_mcont_q) begin
					memory_cycle_restart <= 1'b1;
				end else begin
					master_clear <= 1'b1;
				end
				if (k_rdin) begin
					readin_mode <= 1'b1;
				end else if (~(k_icont | k_mcont)) begin
					readin_mode <= 1'b0;
				end
				if (k_start | k_rdin | k_exa | k_dep) begin
					memory_address_reg <= a2_q;
				end else if (k_exan | k_depn) begin
					memory_address_reg <= memory_address_reg + 18'h0_0001;
				end
				if (is_dep | op_exe_q) begin
					accumulate_register <= d2_q;
				end
				st_q <= op_mcont_q ? `KS_IDLE : `KS_P3;
			end
			`KS_P3: begin
				key_pulse_3 <= 1'b1;
				st_q        <= `KS_IDLE;
				if (op_go_q) begin
					launch_pulse   <= 1'b1;
					master_clear   <= 1'b1;
					operating_flag <= 1'b1;
				end else if (op_exe_q) begin
					buffer_register  <= accumulate_register;
					exec_entry_pulse <= 1'b1;
					key_pulse_4      <= k_rpt;
				end else if (op_rd_q | wr_q) begin
					console_rdwr_flag <= 1'b1;
					mem_read_req      <= op_rd_q;
					mem_write_req     <= wr_q;
					if (wr_q) begin
						buffer_register <= accumulate_register;
					end
					st_q <= `KS_WAIT_MEM;
				end
			end
			`KS_WAIT_MEM: begin
				if (mem_done) begin
					memory_cycle_restart <= 1'b1;
					console_rdwr_flag    <= 1'b0;
					st_q                 <= `KS_P4;
				end
			end
			`KS_P4: begin
				// read/write return gives pulse 4
				key_pulse_4 <= 1'b1;
				st_q        <= `KS_IDLE;
				if (any_start) begin
					launch_pulse <= 1'b1;
					master_clear <= 1'b1;
					start_exa_q  <= 1'b0;
					start_dep_q  <= 1'b0;
				end
			end
			default: begin
				st_q <= `KS_IDLE;
			end
			endcase
		end
	end
endmodule // console_key_sequencer

/* File: rtl/key_seq_defs.vh */
`ifndef KEY_SEQ_DEFS_VH
`define KEY_SEQ_DEFS_VH
// ************************************************************
// widths, field positions and timing
// ************************************************************
`define ADDR_W            18
`define DATA_W            36
`define FAST_MEM_TOP      18'h0_0017
`define EXEC_STOP_BIT     10
`define CLK_PERIOD_NS     10
`define REPEAT_DELAY_NS   200000
// cycle counts sized to the counter width: 200 us and 1 us at the 10 ns clock
`define REPEAT_DELAY_CYC  16'h4E20
`define STOP_PG_DELAY_NS  1000
`define STOP_PG_CYC       16'h0064
`define KEY_CNT_W         16
// key chain states
`define KS_IDLE           3'h0
`define KS_A0             3'h1
`define KS_WAIT_STORE     3'h2
`define KS_P1             3'h3
`define KS_P3             3'h4
`define KS_WAIT_MEM       3'h5
`define KS_P4             3'h6
`define KS_REPEAT         3'h7
`endif

/* File: rtl/key_delay.v */
`timescale 1ns/1ps
`include "key_seq_defs.vh"
// one-shot cycle delay: done pulses once, count cycles after start
module key_delay #(
	parameter [`KEY_CNT_W-1:0] COUNT = 16'h0064
) (
	input  wire                  mclk,
	input  wire                  arst_n,
	input  wire                  start,
	input  wire                  abort,
	output reg                   done
);
	reg [`KEY_CNT_W-1:0] cnt_q;
	reg                  busy_q;

	// ************************************************************
	// counter
	// ************************************************************
	// a restart while busy reloads, so the delay is from the last start
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q  <= 16'h0000;
			busy_q <= 1'b0;
			done   <= 1'b0;
		end else begin
			done <= 1'b0;
			if (abort) begin
				busy_q <= 1'b0;
			end else if (start) begin
				cnt_q  <= COUNT;
				busy_q <= 1'b1;
			end else if (busy_q) begin
				if (cnt_q <= 16'h0001) begin
					busy_q <= 1'b0;
					done   <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 16'h0001;
				end
			end
		end
	end
endmodule // key_delay

/* File: tb/console_key_asserts.sv */
`timescale 1ns/1ps
`include "key_seq_defs.vh"
module console_key_asserts (
	input wire logic               mclk,
	input wire logic               arst_n,
	input wire logic               key_mem_cont,
	input wire logic               execute_pulse_0,
	input wire logic               exec_mode,
	input wire logic               jump_restore_instr,
	input wire logic [`DATA_W-1:0] instr_word,
	input wire logic               inst_fetched,
	input wire logic [`ADDR_W-1:0] fetch_addr,
	input wire logic               master_clear,
	input wire logic               system_init_pulse,
	input wire logic               launch_pulse,
	input wire logic               exec_entry_pulse,
	input wire logic               memory_cycle_restart,
	input wire logic               mem_write_req,
	input wire logic               operating_flag,
	input wire logic               readin_mode,
	input wire logic               console_rdwr_flag,
	input wire logic               key_pulse_a0,
	input wire logic               key_pulse_1,
	input wire logic               key_pulse_3,
	input wire logic               key_pulse_4,
	input wire logic [`DATA_W-1:0] accumulate_register,
	input wire logic [`DATA_W-1:0] buffer_register
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	// ************************************************************
	// key chain steps
	// ************************************************************
	sequence a0_stopped;
		key_pulse_a0 && !operating_flag && !key_mem_cont;
	endsequence
	sequence rdwr_return;
		memory_cycle_restart ##1 key_pulse_4;
	endsequence
	pulse_single_a: assert property (key_pulse_a0 |=> !key_pulse_a0 && !key_pulse_1)
		else $error("key pulse a0 longer than one cycle");
	chain_stopped_a: assert property (a0_stopped |-> ##2 key_pulse_1 ##1 key_pulse_3)
		else $error("stopped chain did not reach pulse 1 and 3");
	memcont_noclr_a: assert property (key_pulse_1 && key_mem_cont
		|-> memory_cycle_restart && !master_clear)
		else $error("memory continue gave master clear or no restart");
	op_clear_a: assert property (key_pulse_1 && !key_mem_cont |-> master_clear)
		else $error("console operation without master clear");
	exec_stopped_a: assert property (exec_entry_pulse |-> !operating_flag)
		else $error("execute entry while running");
	write_copy_a: assert property (mem_write_req
		|-> key_pulse_3 && console_rdwr_flag && buffer_register == accumulate_register)
		else $error("deposit write without buffer copy");
	rdwr_end_a: assert property ($fell(console_rdwr_flag) |-> rdwr_return)
		else $error("read write return out of order");
	launch_run_a: assert property (launch_pulse |-> operating_flag && master_clear)
		else $error("launch without operating flag");
	readin_exit_a: assert property (inst_fetched && fetch_addr > `FAST_MEM_TOP
		|-> ##[1:3] !readin_mode)
		else $error("readin mode kept above fast memory");
	exec_halt_a: assert property (execute_pulse_0 && exec_mode && jump_restore_instr
		&& instr_word[`DATA_W-1-`EXEC_STOP_BIT] |-> ##[1:2] !operating_flag)
		else $error("executive jump restore did not halt");
	init_readin_a: assert property (system_init_pulse |=> !readin_mode)
		else $error("system init left readin mode set");
endmodule // console_key_asserts

/* File: tb/proc_side_model.sv */
`timescale 1ns/1ps
`include "key_seq_defs.vh"
// stand-in for the main sequence and memory: fixed short cycles
module proc_side_model (
	input  wire logic               mclk,
	input  wire logic               arst_n,
	input  wire logic               launch_pulse,
	input  wire logic               next_inst_pulse,
	input  wire logic               exec_entry_pulse,
	input  wire logic               mem_read_req,
	input  wire logic               mem_write_req,
	input  wire logic [`ADDR_W-1:0] fetch_base,
	output logic                    execute_pulse_0,
	output logic                    store_pulse_7,
	output logic                    inst_fetched,
	output logic                    mem_done,
	output logic                    mem_stop_set,
	output logic [`ADDR_W-1:0]      fetch_addr
);
	logic [3:0] step_q;
	logic [1:0] mem_q;
	// address is only meaningful with the fetch strobe; scramble it otherwise
	assign fetch_addr = inst_fetched ? fetch_base : ~fetch_base;
	// instruction: fetch at 2, execute at 4, store end at 7; execute entry skips the fetch
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			step_q <= 4'h0;
			mem_q <= 2'h0;
		end else begin
			if (launch_pulse || next_inst_pulse)
				step_q <= 4'h1;
			else if (exec_entry_pulse)
				step_q <= 4'h3;
			else if (step_q != 4'h0)
				step_q <= (step_q == 4'h7) ? 4'h0 : step_q + 4'h1;
			if (mem_read_req || mem_write_req)
				mem_q <= 2'h3;
			else if (mem_q != 2'h0)
				mem_q <= mem_q - 2'h1;
		end
	end
	assign inst_fetched = (step_q == 4'h2);
	assign execute_pulse_0 = (step_q == 4'h4);
	assign store_pulse_7 = (step_q == 4'h7);
	assign mem_done = (mem_q == 2'h1);
	assign mem_stop_set = 1'b0; // memory stop is not modelled
endmodule // proc_side_model

/* File: tb/console_key_sequencer_bench.sv */
`timescale 1ns/1ps
`include "key_seq_defs.vh"
module console_key_sequencer_bench;
	logic               mclk, arst_n, power_clear, sw_repeat, exec_mode, jump_restore_instr;
	logic [12:0]        keys;
	logic [`ADDR_W-1:0] sw_address, fetch_base;
	logic [`DATA_W-1:0] sw_data, instr_word;
	wire                ep0, st7, ifet, mdone, mstop, mclr, sinit, launch, nxt, xent, mcr;
	wire                rreq, wreq, opf, rim, rdwr, a0, k1, k3, k4;
	wire [`ADDR_W-1:0]  ma, faddr;
	wire [`DATA_W-1:0]  ar, mb;
	int                 num_errors, tests_run, n_k4, n_sinit, n;
	// short repeat and stop delays keep the run brief
	console_key_sequencer #(.REPEAT_CYC(16'h0004), .STOP_PG_CYC(16'h0003)) i_dut (
		.mclk(mclk), .arst_n(arst_n), .power_clear(power_clear), .key_start(keys[0]),
		.key_read_in(keys[1]), .key_inst_cont(keys[2]), .key_mem_cont(keys[3]),
		.key_examine(keys[4]), .key_examine_next(keys[5]), .key_deposit(keys[6]),
		.key_deposit_next(keys[7]), .key_execute(keys[8]), .key_io_reset(keys[9]),
		.key_exec_mode(keys[10]), .key_inst_stop(keys[11]), .key_mem_stop(keys[12]),
		.sw_repeat(sw_repeat), .sw_address(sw_address), .sw_data(sw_data),
		.execute_pulse_0(ep0), .exec_mode(exec_mode), .jump_restore_instr(jump_restore_instr),
		.instr_word(instr_word), .store_pulse_7(st7), .inst_fetched(ifet), .fetch_addr(faddr),
		.mem_done(mdone), .mem_stop_set(mstop), .master_clear(mclr), .system_init_pulse(sinit),
		.launch_pulse(launch), .next_inst_pulse(nxt), .exec_entry_pulse(xent),
		.memory_cycle_restart(mcr), .mem_read_req(rreq), .mem_write_req(wreq),
		.operating_flag(opf), .readin_mode(rim), .console_rdwr_flag(rdwr),
		.key_pulse_a0(a0), .key_pulse_1(k1), .key_pulse_3(k3), .key_pulse_4(k4),
		.memory_address_reg(ma), .accumulate_register(ar), .buffer_register(mb));
	proc_side_model i_proc (.mclk(mclk), .arst_n(arst_n), .launch_pulse(launch),
		.next_inst_pulse(nxt), .exec_entry_pulse(xent), .mem_read_req(rreq),
		.mem_write_req(wreq), .fetch_base(fetch_base), .execute_pulse_0(ep0),
		.store_pulse_7(st7), .inst_fetched(ifet), .mem_done(mdone), .mem_stop_set(mstop),
		.fetch_addr(faddr));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// pulse tallies, read by the repeat and init checks
	always @(posedge mclk) begin
		if (k4 === 1'b1) n_k4++;
		if (sinit === 1'b1) n_sinit++;
	end
	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// bounded wait for one design event, sampled after the edge has settled
	task automatic wait_on(input int sel);
		int i;
		bit hit;
		hit = 0;
		for (i = 0; i < 400 && !hit; i++) begin
			@(posedge mclk);
			#1;
			case (sel)
				0: hit = (k4 === 1'b1);
				1: hit = (launch === 1'b1);
				2: hit = (mcr === 1'b1);
				3: hit = (xent === 1'b1);
				4: hit = (opf === 1'b0);
				5: hit = (rim === 1'b0);
				6: hit = (ep0 === 1'b1);
				default: hit = (sinit === 1'b1);
			endcase
		end
		if (!hit) begin
			num_errors++;
			$display("Error event %0d expected 1 seen 0", sel);
		end
	endtask
	// hold a key until its event, then let the chain fall idle
	task automatic press(input int k, input int sel);
		@(posedge mclk) keys[k] <= 1'b1;
		wait_on(sel);
		@(posedge mclk) keys[k] <= 1'b0;
		repeat (8) @(posedge mclk);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// watchdog: whole sequence needs well under 20000 cycles
	initial begin
		#200_000;
		num_errors++;
		$display("Error watchdog expected done seen hang");
		finish_test;
	end
	initial begin
		arst_n = 1'b0; power_clear = 1'b0; sw_repeat = 1'b0; exec_mode = 1'b0;
		jump_restore_instr = 1'b0; keys = '0; sw_address = 18'h0_0123;
		sw_data = 36'h1_2345_6789; instr_word = '0; fetch_base = 18'h0_0010;
		num_errors = 0; tests_run = 0; n_k4 = 0; n_sinit = 0;
		repeat (8) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk) power_clear <= 1'b1;
		wait_on(7);
		@(posedge mclk) power_clear <= 1'b0;
		press(9, 7);
		press(10, 7);
		check("init", n_sinit, 3);
		$display("test init done");
		press(6, 0);
		check("ma", ma, sw_address);
		check("ar", ar, sw_data);
		check("mb", mb, sw_data);
		check("rdwr", rdwr, 0);
		press(5, 0);
		check("ma_next", ma, sw_address + 18'h0_0001);
		sw_data <= 36'h0_ABCD_0000;
		press(7, 0);
		check("ma_next2", ma, sw_address + 18'h0_0002);
		check("ar_next", ar, 36'h0_ABCD_0000);
		$display("test deposit done");
		press(8, 3);
		check("exec_mb", mb, 36'h0_ABCD_0000);
		check("exec_run", opf, 0);
		press(3, 2);
		check("cont_run", opf, 0);
		$display("test execute done");
		press(1, 1);
		check("readin", rim, 1);
		check("run", opf, 1);
		wait_on(6);
		wait_on(6);
		check("readin_low", rim, 1);
		@(posedge mclk) fetch_base <= 18'h0_0020;
		wait_on(5);
		$display("test read in done");
		press(4, 0);
		check("exam_run", opf, 1);
		check("exam_ma", ma, sw_address);
		jump_restore_instr <= 1'b1;
		instr_word <= 36'h0_0200_0000;
		wait_on(6);
		wait_on(6);
		check("user_halt", opf, 1);
		@(posedge mclk) exec_mode <= 1'b1;
		wait_on(4);
		@(posedge mclk) exec_mode <= 1'b0;
		jump_restore_instr <= 1'b0;
		$display("test halt done");
		press(0, 1);
		@(posedge mclk) keys[11] <= 1'b1;
		wait_on(4);
		@(posedge mclk) keys[11] <= 1'b0;
		check("stop", opf, 0);
		sw_repeat <= 1'b1;
		keys[4] <= 1'b1;
		n = n_k4;
		wait_on(0);
		wait_on(0);
		@(posedge mclk) keys[4] <= 1'b0;
		sw_repeat <= 1'b0;
		repeat (20) @(posedge mclk);
		check("repeat", n_k4 - n, 2);
		$display("test repeat done");
		finish_test;
	end
endmodule // console_key_sequencer_bench
bind console_key_sequencer console_key_asserts u_chk (
	.mclk(mclk), .arst_n(arst_n), .key_mem_cont(key_mem_cont),
	.execute_pulse_0(execute_pulse_0), .exec_mode(exec_mode),
	.jump_restore_instr(jump_restore_instr), .instr_word(instr_word),
	.inst_fetched(inst_fetched), .fetch_addr(fetch_addr), .master_clear(master_clear),
	.system_init_pulse(system_init_pulse), .launch_pulse(launch_pulse),
	.exec_entry_pulse(exec_entry_pulse), .memory_cycle_restart(memory_cycle_restart),
	.mem_write_req(mem_write_req), .operating_flag(operating_flag),
	.readin_mode(readin_mode), .console_rdwr_flag(console_rdwr_flag),
	.key_pulse_a0(key_pulse_a0), .key_pulse_1(key_pulse_1), .key_pulse_3(key_pulse_3),
	.key_pulse_4(key_pulse_4), .accumulate_register(accumulate_register),
	.buffer_register(buffer_register));
